// *** rtl/ufp_parser.sv ***
`timescale 1ns/1ps
module ufp_parser
  import ufp_pkg::*;
#(
  parameter int MS_CYC = MS_CYCLES
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Received host bytes
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_valid,
  // Frame byte stream out
  output logic      [7:0]  frm_data,
  output logic             frm_valid,
  output logic             frm_first,
  output logic             frm_done,
  output ufp_frm_s         frm_info,
  // Acknowledge stream to host
  output logic      [7:0]  tx_data,
  output logic             tx_valid,
  input  wire logic        tx_ready
);

  ufp_cfg_s    cfg_reg, cfg_next;
  logic        wpend_reg, wpend_next;
  logic [7:0]  waddr_reg, waddr_next;
  logic [31:0] rdata_next;
  logic        ack_wr;
  logic [15:0] good_cnt_reg, good_cnt_next;
  logic [15:0] bad_cnt_reg, bad_cnt_next;

  ufp_st_e     st_reg, st_next;
  logic [15:0] cnt_reg, cnt_next;
  logic [8:0]  tot_reg, tot_next;
  logic        known_reg, known_next;
  logic        bad_reg, bad_next;
  logic        match_reg, match_next;
  logic [31:0] ms_reg, ms_next;
  logic [15:0] gap_reg, gap_next;
  logic [7:0]  fd_next;
  logic        fv_next, ff_next, fdn_next;
  ufp_frm_s    info_next;
  logic        ack_go_reg, ack_go_next;

  logic        xparent, gap_exp, fresh, last, in_addr;
  logic [15:0] idx;
  logic [7:0]  aoff;
  logic [3:0]  k;
  logic [7:0]  own_b;
  logic [8:0]  aend;

  // Bus address phase; zero wait states, reads registered into the data phase.
  // Reads look through cfg_next so a read right behind a write sees the new value.
  always_comb begin
    wpend_next = 1'b0;
    waddr_next = waddr_reg;
    rdata_next = hrdata;
    if (hsel && hready && htrans[1]) begin
      wpend_next = hwrite;
      waddr_next = haddr[7:0];
      rdata_next = 32'h0000_0000;
      if (!hwrite) begin
        case (haddr[7:0])
          ADR_CTRL:   rdata_next = {28'h0, cfg_next.chk, cfg_next.down_dir, cfg_next.enable};
          ADR_LEN:    rdata_next = {16'h0, cfg_next.len_amend, cfg_next.len_off};
          ADR_SYNC:   rdata_next = {16'h0, cfg_next.sync_stop, cfg_next.sync_start};
          ADR_ADDR:   rdata_next = {11'h0, cfg_next.addr_len, cfg_next.up_off, cfg_next.dn_off};
          ADR_WILD:   rdata_next = {16'h0, cfg_next.mcast_wc, cfg_next.bcast_wc};
          ADR_GAP:    rdata_next = {16'h0, cfg_next.gap_ms};
          ADR_STAT:   rdata_next = {bad_cnt_reg, good_cnt_reg};
          ADR_ACKLEN: rdata_next = {26'h0, cfg_next.ack_len};
          ADR_OWN0:   rdata_next = cfg_next.own_addr[31:0];
          ADR_OWN1:   rdata_next = cfg_next.own_addr[63:32];
          ADR_OWN2:   rdata_next = cfg_next.own_addr[95:64];
          ADR_OWN3:   rdata_next = cfg_next.own_addr[127:96];
          default:    rdata_next = 32'h0000_0000;
        endcase
      end
    end
  end

  // Bus data phase writes; unmapped offsets are ignored
  always_comb begin
    cfg_next = cfg_reg;
    ack_wr   = 1'b0;
    if (wpend_reg) begin
      case (waddr_reg)
        ADR_CTRL: begin
          cfg_next.enable   = hwdata[POS_EN];
          cfg_next.down_dir = hwdata[POS_DOWN];
          cfg_next.chk      = ufp_chk_e'(hwdata[POS_CHK +: 2]);
        end
        ADR_LEN: begin
          cfg_next.len_off   = hwdata[7:0];
          cfg_next.len_amend = hwdata[POS_B1 +: 8];
        end
        ADR_SYNC: begin
          cfg_next.sync_start = hwdata[7:0];
          cfg_next.sync_stop  = hwdata[POS_B1 +: 8];
        end
        ADR_ADDR: begin
          cfg_next.dn_off   = hwdata[7:0];
          cfg_next.up_off   = hwdata[POS_B1 +: 8];
          cfg_next.addr_len = hwdata[POS_ALEN +: 5];
        end
        ADR_WILD: begin
          cfg_next.bcast_wc = hwdata[7:0];
          cfg_next.mcast_wc = hwdata[POS_B1 +: 8];
        end
        ADR_GAP:    cfg_next.gap_ms = hwdata[15:0];
        ADR_ACKLEN: cfg_next.ack_len = (hwdata[5:0] > ACK_MAX_V) ? ACK_MAX_V : hwdata[5:0];
        ADR_ACKDAT: ack_wr = 1'b1;
        ADR_OWN0:   cfg_next.own_addr[31:0]   = hwdata;
        ADR_OWN1:   cfg_next.own_addr[63:32]  = hwdata;
        ADR_OWN2:   cfg_next.own_addr[95:64]  = hwdata;
        ADR_OWN3:   cfg_next.own_addr[127:96] = hwdata;
        default:    cfg_next = cfg_reg;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_reg   <= CFG_RST;
      wpend_reg <= 1'b0;
      waddr_reg <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      cfg_reg   <= cfg_next;
      wpend_reg <= wpend_next;
      waddr_reg <= waddr_next;
      hrdata    <= rdata_next;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Frame parser; transparent when no sync check is selected
  always_comb begin
    xparent    = (cfg_reg.chk == UFP_CHK_NONE);
    gap_exp    = (st_reg == UFP_ST_RECV) && (gap_reg > cfg_reg.gap_ms);
    fresh      = (st_reg == UFP_ST_IDLE) || gap_exp;
    idx        = fresh ? 16'h0000 : cnt_reg;
    aoff       = cfg_reg.down_dir ? cfg_reg.dn_off : cfg_reg.up_off;
    aend       = {1'b0, aoff} + {4'h0, cfg_reg.addr_len};
    in_addr    = !xparent && aoff != OFF_NONE && idx >= {8'h00, aoff}
                 && idx < {7'h00, aend};
    k          = 4'(idx - {8'h00, aoff});
    own_b      = cfg_reg.own_addr[{k, 3'b000} +: 8];
    last       = 1'b0;
    st_next    = st_reg;
    cnt_next   = cnt_reg;
    tot_next   = tot_reg;
    known_next = known_reg;
    bad_next   = bad_reg;
    match_next = match_reg;
    fd_next    = frm_data;
    fv_next    = 1'b0;
    ff_next    = 1'b0;
    fdn_next   = 1'b0;
    info_next  = frm_info;
    // Millisecond prescaler and gap count since the last byte
    ms_next    = (ms_reg >= 32'(MS_CYC - 1)) ? 32'h0000_0000 : ms_reg + 32'h0000_0001;
    gap_next   = (ms_reg >= 32'(MS_CYC - 1) && gap_reg != 16'hFFFF) ? gap_reg + 16'h0001
                                                                     : gap_reg;
    // Gap closes the frame: good in transparent mode, discarded otherwise
    if (gap_exp) begin
      st_next              = UFP_ST_IDLE;
      fdn_next             = 1'b1;
      info_next.good       = xparent && !bad_reg;
      info_next.bcast      = 1'b1;
      info_next.addr_match = match_reg;
      info_next.len        = cnt_reg;
    end
    if (rx_valid && cfg_reg.enable) begin
      st_next    = UFP_ST_RECV;
      gap_next   = 16'h0000;
      ms_next    = 32'h0000_0000;
      cnt_next   = idx + 16'h0001;
      fd_next    = rx_data;
      fv_next    = 1'b1;
      ff_next    = fresh;
      if (fresh) begin
        bad_next   = 1'b0;
        match_next = 1'b1;
        known_next = (cfg_reg.len_off == OFF_NONE);
        tot_next   = {1'b0, cfg_reg.len_amend};
      end
      // Start sync on first byte when enabled
      if (cfg_reg.chk[0] && idx == 16'h0000 && rx_data != cfg_reg.sync_start) begin
        bad_next = 1'b1;
      end
      // Variable length taken from the length byte
      if (!xparent && cfg_reg.len_off != OFF_NONE && idx == {8'h00, cfg_reg.len_off}) begin
        known_next = 1'b1;
        tot_next   = {1'b0, rx_data} + {1'b0, cfg_reg.len_amend};
      end
      // Address filter; wildcard bytes always pass
      if (in_addr && rx_data != cfg_reg.bcast_wc && rx_data != cfg_reg.mcast_wc
          && rx_data != own_b) begin
        match_next = 1'b0;
      end
      last = !xparent && known_next && cnt_next >= {7'h00, tot_next};
      if (last) begin
        st_next              = UFP_ST_IDLE;
        fdn_next             = 1'b1;
        if (cfg_reg.chk[1] && rx_data != cfg_reg.sync_stop) begin
          bad_next = 1'b1;
        end
        info_next.good       = !bad_next;
        info_next.bcast      = (aoff == OFF_NONE);
        info_next.addr_match = match_next;
        info_next.len        = cnt_next;
      end
    end
    ack_go_next   = fdn_next && info_next.good;
    good_cnt_next = good_cnt_reg + {15'h0000, ack_go_next};
    bad_cnt_next  = bad_cnt_reg + {15'h0000, fdn_next && !info_next.good};
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg       <= UFP_ST_IDLE;
      cnt_reg      <= 16'h0000;
      tot_reg      <= 9'h000;
      known_reg    <= 1'b0;
      bad_reg      <= 1'b0;
      match_reg    <= 1'b1;
      ms_reg       <= 32'h0000_0000;
      gap_reg      <= 16'h0000;
      frm_data     <= 8'h00;
      frm_valid    <= 1'b0;
      frm_first    <= 1'b0;
      frm_done     <= 1'b0;
      frm_info     <= FRM_RST;
      ack_go_reg   <= 1'b0;
      good_cnt_reg <= 16'h0000;
      bad_cnt_reg  <= 16'h0000;
    end else begin
      st_reg       <= st_next;
      cnt_reg      <= cnt_next;
      tot_reg      <= tot_next;
      known_reg    <= known_next;
      bad_reg      <= bad_next;
      match_reg    <= match_next;
      ms_reg       <= ms_next;
      gap_reg      <= gap_next;
      frm_data     <= fd_next;
      frm_valid    <= fv_next;
      frm_first    <= ff_next;
      frm_done     <= fdn_next;
      frm_info     <= info_next;
      ack_go_reg   <= ack_go_next;
      good_cnt_reg <= good_cnt_next;
      bad_cnt_reg  <= bad_cnt_next;
    end
  end

  // Acknowledge packet store and sender
  ufp_ack_tx u_ack (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .wr_en    (ack_wr),
    .wr_idx   (hwdata[POS_ACKIDX +: 6]),
    .wr_data  (hwdata[7:0]),
    .ack_len  (cfg_reg.ack_len),
    .start    (ack_go_reg),
    .tx_data  (tx_data),
    .tx_ready (tx_ready),
    .tx_valid (tx_valid)
  );

endmodule : ufp_parser

// *** rtl/ufp_pkg.sv ***
package ufp_pkg;

  // Register byte offsets
  localparam logic [7:0] ADR_CTRL   = 8'h00;
  localparam logic [7:0] ADR_LEN    = 8'h04;
  localparam logic [7:0] ADR_SYNC   = 8'h08;
  localparam logic [7:0] ADR_ADDR   = 8'h0C;
  localparam logic [7:0] ADR_WILD   = 8'h10;
  localparam logic [7:0] ADR_GAP    = 8'h14;
  localparam logic [7:0] ADR_STAT   = 8'h18;
  localparam logic [7:0] ADR_ACKLEN = 8'h1C;
  localparam logic [7:0] ADR_ACKDAT = 8'h20;
  localparam logic [7:0] ADR_OWN0   = 8'h30;
  localparam logic [7:0] ADR_OWN1   = 8'h34;
  localparam logic [7:0] ADR_OWN2   = 8'h38;
  localparam logic [7:0] ADR_OWN3   = 8'h3C;

  // Field positions
  localparam int POS_EN      = 0;
  localparam int POS_DOWN    = 1;
  localparam int POS_CHK     = 2;
  localparam int POS_B1      = 8;
  localparam int POS_ALEN    = 16;
  localparam int POS_ACKIDX  = 8;

  // Sizes and special values
  localparam logic [7:0] OFF_NONE  = 8'hFF;
  localparam int         ACK_MAX   = 48;
  localparam logic [5:0] ACK_MAX_V = 6'h30;

  // Timing: gap timeout counted in milliseconds
  localparam int CLK_HZ     = 125_000_000;
  localparam int GAP_UNIT_MS = 1;
  localparam int MS_CYCLES  = CLK_HZ / 1000 * GAP_UNIT_MS;

  typedef enum logic [1:0] {
    UFP_CHK_NONE  = 2'b00,
    UFP_CHK_START = 2'b01,
    UFP_CHK_STOP  = 2'b10,
    UFP_CHK_BOTH  = 2'b11
  } ufp_chk_e;

  typedef enum logic [0:0] {
    UFP_ST_IDLE = 1'b0,
    UFP_ST_RECV = 1'b1
  } ufp_st_e;

  typedef struct packed {
    logic         enable;
    logic         down_dir;
    ufp_chk_e     chk;
    logic [7:0]   len_off;
    logic [7:0]   len_amend;
    logic [7:0]   sync_start;
    logic [7:0]   sync_stop;
    logic [7:0]   dn_off;
    logic [7:0]   up_off;
    logic [4:0]   addr_len;
    logic [7:0]   bcast_wc;
    logic [7:0]   mcast_wc;
    logic [15:0]  gap_ms;
    logic [5:0]   ack_len;
    logic [127:0] own_addr;
  } ufp_cfg_s;

  typedef struct packed {
    logic        good;
    logic        bcast;
    logic        addr_match;
    logic [15:0] len;
  } ufp_frm_s;

  // Reset values
  localparam ufp_cfg_s CFG_RST = '{
    enable: 1'b0, down_dir: 1'b0, chk: UFP_CHK_NONE,
    len_off: 8'hFF, len_amend: 8'hFF, sync_start: 8'h00, sync_stop: 8'h00,
    dn_off: 8'hFF, up_off: 8'hFF, addr_len: 5'h01, bcast_wc: 8'h00,
    mcast_wc: 8'h00, gap_ms: 16'h0001, ack_len: 6'h00, own_addr: 128'h0
  };
  localparam ufp_frm_s FRM_RST = '{good: 1'b0, bcast: 1'b0, addr_match: 1'b0, len: 16'h0000};

endpackage : ufp_pkg

// *** rtl/ufp_ack_tx.sv ***
`timescale 1ns/1ps
module ufp_ack_tx
  import ufp_pkg::*;
(
  // Clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // Packet store write port
  input  wire logic       wr_en,
  input  wire logic [5:0] wr_idx,
  input  wire logic [7:0] wr_data,
  input  wire logic [5:0] ack_len,
  // Send request
  input  wire logic       start,
  // Byte stream to host
  output logic      [7:0] tx_data,
  input  wire logic       tx_ready,
  output logic            tx_valid
);

  logic [7:0] mem_reg [ACK_MAX];
  logic [5:0] idx_reg, idx_next;
  logic [7:0] dat_next;
  logic       vld_next;

  // One flop row per stored byte
  genvar g;
  generate
    for (g = 0; g < ACK_MAX; g++) begin : g_mem
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          mem_reg[g] <= 8'h00;
        end else if (wr_en && wr_idx == 6'(g)) begin
          mem_reg[g] <= wr_data;
        end
      end
    end
  endgenerate

  // Send sequencer; a request while busy is dropped, an empty packet sends nothing
  always_comb begin
    idx_next = idx_reg;
    dat_next = tx_data;
    vld_next = tx_valid;
    if (!tx_valid) begin
      if (start && ack_len != 6'h00) begin
        idx_next = 6'h00;
        dat_next = mem_reg[0];
        vld_next = 1'b1;
      end
    end else if (tx_ready) begin
      idx_next = idx_reg + 6'h01;
      if (idx_next >= ack_len || idx_next >= ACK_MAX_V) begin
        vld_next = 1'b0;
      end else begin
        dat_next = mem_reg[idx_next];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idx_reg  <= 6'h00;
      tx_data  <= 8'h00;
      tx_valid <= 1'b0;
    end else begin
      idx_reg  <= idx_next;
      tx_data  <= dat_next;
      tx_valid <= vld_next;
    end
  end

endmodule : ufp_ack_tx

// *** tb/ufp_parser_assertions.sv ***
`timescale 1ns/1ps
module ufp_parser_chk
  import ufp_pkg::*;
(
  // Clock and reset
  input wire logic       hclk,
  input wire logic       hresetn,
  // Byte streams
  input wire logic [7:0] rx_data,
  input wire logic       rx_valid,
  input wire logic [7:0] frm_data,
  input wire logic       frm_valid,
  input wire logic       frm_first,
  input wire logic       frm_done,
  input wire ufp_frm_s   frm_info,
  input wire logic [7:0] tx_data,
  input wire logic       tx_valid,
  input wire logic       tx_ready
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [15:0] nb_reg;
  logic [15:0] nb_next;
  // Bytes forwarded since the frame began, including this cycle
  always_comb nb_next = !frm_valid ? nb_reg : (frm_first ? 16'h0001 : nb_reg + 16'h0001);
  // Count register; as wide as the frame length field so long frames still match
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn) nb_reg <= 16'h0000;
    else nb_reg <= nb_next;

  property p_echo; frm_valid |-> $past(rx_valid) && frm_data == $past(rx_data); endproperty
  a_echo: assert property (p_echo) else $error("forwarded byte differs");
  property p_first; frm_first |-> frm_valid; endproperty
  a_first: assert property (p_first) else $error("first flag without byte");
  property p_len; frm_done |-> frm_info.len == nb_next; endproperty
  a_len: assert property (p_len) else $error("frame length differs from byte count");
  property p_info; $changed(frm_info) |-> frm_done; endproperty
  a_info: assert property (p_info) else $error("frame info moved without done");
  property p_tx_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data); endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("ack byte dropped while stalled");
  property p_ack_cause; $rose(tx_valid) |-> $past(frm_done && frm_info.good, 1); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without good frame");
  property p_bad_quiet; frm_done && !frm_info.good |-> ##1 !$rose(tx_valid); endproperty
  a_bad_quiet: assert property (p_bad_quiet) else $error("ack after bad frame");
  property p_restart; frm_valid && $past(frm_done && !frm_first) |-> frm_first; endproperty
  a_restart: assert property (p_restart) else $error("byte after done not first");

  // Main scenarios reached
  c_good: cover property (frm_done && frm_info.good);
  c_bad: cover property (frm_done && !frm_info.good);
  c_stall: cover property (tx_valid && !tx_ready);
endmodule : ufp_parser_chk

// *** tb/ufp_host_model.sv ***
`timescale 1ns/1ps
module ufp_host_model (
  // Clock and reset
  input wire logic       hclk,
  input wire logic       hresetn,
  // Bytes toward the parser
  output logic     [7:0] rx_data,
  output logic           rx_valid,
  // Acknowledge bytes back
  input wire logic [7:0] tx_data,
  input wire logic       tx_valid,
  output logic           tx_ready
);
  logic       slow = 1'b0;
  logic [7:0] got[$];
  initial begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
    tx_ready = 1'b0;
  end
  // Caller places start and stop sync bytes so checks can be on
  task automatic send(input logic [7:0] b[$], input int sp);
    foreach (b[i]) begin
      rx_valid <= 1'b1;
      rx_data <= b[i];
      @(posedge hclk);
      if (sp != 0 || i == b.size() - 1) begin
        rx_valid <= 1'b0;
        rx_data <= ~b[i]; // Idle line never repeats the last byte
        repeat (sp) @(posedge hclk);
      end
    end
  endtask : send
  // Slow sink stalls every other cycle
  always @(posedge hclk) begin
    tx_ready <= !hresetn ? 1'b0 : (slow ? ~tx_ready : 1'b1);
    if (tx_valid && tx_ready) got.push_back(tx_data);
  end
endmodule : ufp_host_model

// *** tb/uart_frame_boundary_parser_tb_top.sv ***
`timescale 1ns/1ps
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin mismatches++; \
  $display("[FAIL] %s expected %0h seen %0h", n, e, a); end end
module uart_frame_boundary_parser_tb_top;
  import ufp_pkg::*;
  localparam int MSC = 10; // Short millisecond keeps gap runs brief
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, seen;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  rx_data, frm_data, tx_data;
  logic        rx_valid, frm_valid, frm_first, frm_done, tx_valid, tx_ready;
  ufp_frm_s    frm_info, info;
  int          mismatches = 0, total_checks = 0, cyc = 0, wn;

  ufp_parser #(.MS_CYC(MSC)) u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .rx_data, .rx_valid, .frm_data,
    .frm_valid, .frm_first, .frm_done, .frm_info, .tx_data, .tx_valid, .tx_ready);
  ufp_host_model u_host (.hclk, .hresetn, .rx_data, .rx_valid, .tx_data, .tx_valid, .tx_ready);

  // Clock and hang guard
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 30000) begin
      mismatches++;
      finish_test();
    end
  end

  task finish_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test

  // Single word transfer; waits on the slave rather than assuming latency
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : ahb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask : wr
  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    `CHK(n, e, r)
    `CHK("hresp", 1'b0, hresp)
  endtask : rd

  // Send one frame, judge its close and the acknowledge that follows
  task automatic frame(input logic [7:0] b[$], input int sp, input logic eg, input int nack);
    u_host.got.delete();
    u_host.send(b, sp);
    seen = 1'b0;
    wn = 0;
    while (!seen && wn < 80) begin
      @(posedge hclk);
      wn++;
      if (frm_done === 1'b1) begin
        seen = 1'b1;
        info = frm_info;
      end
    end
    `CHK("frm_done", 1'b1, seen)
    `CHK("good", eg, info.good)
    `CHK("len", 16'(b.size()), info.len)
    repeat (60) @(posedge hclk);
    `CHK("ack count", nack, u_host.got.size())
    foreach (u_host.got[i]) `CHK("ack byte", 8'(8'hA0 + i), u_host.got[i])
  endtask : frame

  task t_regs();
    rd("ctrl", ADR_CTRL, 32'h0);
    rd("len cfg", ADR_LEN, 32'h0000FFFF);
    rd("addr cfg", ADR_ADDR, 32'h0001FFFF);
    wr(8'h28, 32'hFFFFFFFF);
    rd("unmapped", 8'h28, 32'h0);
    wr(ADR_ACKLEN, 32'h3F);
    rd("ack clamp", ADR_ACKLEN, 32'h30);
    for (int i = 0; i < 3; i++) wr(ADR_ACKDAT, {18'h0, 6'(i), 8'(8'hA0 + i)});
    wr(ADR_ACKLEN, 32'h3);
    $display("t_regs end");
  endtask : t_regs

  task t_fixed();
    u_host.slow = 1'b1;
    wr(ADR_LEN, 32'h04FF);
    wr(ADR_SYNC, 32'h1668);
    wr(ADR_CTRL, 32'hD);
    frame('{8'h68, 8'h11, 8'h22, 8'h16}, 0, 1'b1, 3);
    frame('{8'h68, 8'h11, 8'h22, 8'h17}, 0, 1'b0, 0);
    for (int m = 1; m < 4; m++) begin
      wr(ADR_CTRL, {28'h0, 2'(m), 2'b01});
      frame('{8'h55, 8'h11, 8'h22, 8'h16}, 0, m == 2, (m == 2) ? 3 : 0);
    end
    $display("t_fixed end");
  endtask : t_fixed

  task t_var();
    wr(ADR_CTRL, 32'hD);
    wr(ADR_LEN, 32'h0302);
    frame('{8'h68, 8'hAA, 8'h02, 8'h55, 8'h16}, 0, 1'b1, 3);
    frame('{8'h68, 8'hAA, 8'h01, 8'h16}, 0, 1'b1, 3);
    $display("t_var end");
  endtask : t_var

  task t_addr();
    wr(ADR_LEN, 32'h04FF);
    wr(ADR_ADDR, 32'h0002FF01);
    wr(ADR_WILD, 32'hDDEE);
    wr(ADR_OWN0, 32'h3412);
    wr(ADR_CTRL, 32'hF);
    frame('{8'h68, 8'h12, 8'hEE, 8'h16}, 0, 1'b1, 3);
    `CHK("match bcast wc", 1'b1, info.addr_match)
    `CHK("bcast down", 1'b0, info.bcast)
    frame('{8'h68, 8'h12, 8'h35, 8'h16}, 0, 1'b1, 3);
    `CHK("no match", 1'b0, info.addr_match)
    frame('{8'h68, 8'hDD, 8'h34, 8'h16}, 0, 1'b1, 3);
    `CHK("match mcast wc", 1'b1, info.addr_match)
    wr(ADR_CTRL, 32'hD);
    frame('{8'h68, 8'h12, 8'h34, 8'h16}, 0, 1'b1, 3);
    `CHK("bcast up off", 1'b1, info.bcast)
    $display("t_addr end");
  endtask : t_addr

  task t_gap();
    wr(ADR_GAP, 32'h2);
    wr(ADR_CTRL, 32'h1);
    frame('{8'h01, 8'h68, 8'h03}, 15, 1'b1, 3);
    `CHK("gap close time", 1'b1, wn >= 4 && wn <= 30)
    `CHK("bcast opaque", 1'b1, info.bcast)
    $display("t_gap end");
  endtask : t_gap

  // Main sequence
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'b00;
    haddr = 32'h0;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_fixed();
    t_var();
    t_addr();
    t_gap();
    finish_test();
  end
endmodule : uart_frame_boundary_parser_tb_top

bind ufp_parser ufp_parser_chk u_chk (.hclk, .hresetn, .rx_data, .rx_valid, .frm_data,
  .frm_valid, .frm_first, .frm_done, .frm_info, .tx_data, .tx_valid, .tx_ready);
